// File: bench/olm_host.sv
// Host model that issues one-byte program and read requests.
`default_nettype none
module olm_host (
   input  wire logic              clk,
   output var  olm_pkg::olm_req_s req,
   input  wire olm_pkg::olm_rsp_s rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // Requests pulse for one cycle; the address is driven as given, with no range check.
   task automatic xfer(input logic p, input logic [9:0] a,
                       input logic [7:0] d, output olm_pkg::olm_rsp_s r);
      @(negedge clk);
      req = '{prog: p, rd: !p, addr: a, data: d};
      @(negedge clk);
      // Released lines carry the inverse so stale values never match.
      req = '{prog: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
      r = rsp;
   endtask
endmodule
`default_nettype wire

// File: bench/olm_otp_lock_map_tb.sv
// Self-checking bench for the one-time area lock map.
`default_nettype none
module olm_otp_lock_map_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              clk_en = 1'b1;
   olm_pkg::olm_req_s req;
   olm_pkg::olm_rsp_s rsp;
   logic [31:0]       region_locked;
   int                fail_count = 0;
   int                compares = 0;
   always #2 clk = ~clk;
   olm_host host (.clk(clk), .req(req), .rsp(rsp));
   olm_otp_lock_map DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .req(req), .rsp(rsp), .region_locked(region_locked));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic prog(input logic [9:0] a, input logic [7:0] d,
                       input logic rej);
      olm_pkg::olm_rsp_s r;
      host.xfer(1'b1, a, d, r);
      check({r.done, r.rejected}, {1'b1, rej});
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      olm_pkg::olm_rsp_s r;
      host.xfer(1'b0, a, 8'hFF, r);
      check({r.valid, r.data}, {1'b1, exp});
   endtask
   task automatic t_serial();
      prog(10'h102, 8'h5A, 1'b0);
      rd(10'h102, 8'h5A);
      prog(10'h102, 8'hF0, 1'b0);
      rd(10'h102, 8'h50);
      prog(10'h100, 8'hFE, 1'b0);
      prog(10'h102, 8'h00, 1'b1);
      rd(10'h102, 8'h50);
      prog(10'h10A, 8'h11, 1'b0);
      prog(10'h100, 8'h00, 1'b0);
      rd(10'h100, 8'hFC);
      prog(10'h100, 8'hFF, 1'b0);
      rd(10'h100, 8'hFC);
      prog(10'h10A, 8'h00, 1'b1);
   endtask
   task automatic t_user();
      prog(10'h112, 8'hFE, 1'b0);
      prog(10'h114, 8'h00, 1'b1);
      rd(10'h114, 8'hFF);
      prog(10'h124, 8'h00, 1'b0);
      prog(10'h113, 8'h7F, 1'b0);
      prog(10'h204, 8'h00, 1'b1);
      prog(10'h214, 8'hFE, 1'b0);
      prog(10'h216, 8'h00, 1'b1);
      prog(10'h215, 8'h00, 1'b0);
      rd(10'h215, 8'h80);
      prog(10'h2F6, 8'h00, 1'b1);
      @(negedge clk);
      check(region_locked, 32'hFC06_0007);
   endtask
   task automatic t_range();
      prog(10'h0FF, 8'h00, 1'b1);
      prog(10'h300, 8'h00, 1'b1);
      rd(10'h2FF, 8'hFF);
   endtask
   task automatic t_reset();
      olm_pkg::olm_rsp_s r;
      @(negedge clk);
      sys_rst = 1'b1;
      @(negedge clk);
      sys_rst = 1'b0;
      clk_en = 1'b0;
      check(region_locked, 32'h0000_0000);
      host.xfer(1'b1, 10'h116, 8'h00, r);
      check({31'h0000_0000, r.done}, 32'h0000_0000);
      clk_en = 1'b1;
      rd(10'h116, 8'hFF);
      rd(10'h102, 8'h50);
      @(negedge clk);
      check(region_locked, 32'hFC06_0007);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      t_serial();
      t_user();
      t_range();
      t_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// File: include/olm_pkg.sv
// Package with the address map and lock layout of the one-time area.
// Operation
// - Lock bits, once programmed, never clear.
// - Byte 0x100 bit 0 locks lower serial.
// - Byte 0x100 bit 1 locks upper serial.
// - Bits 2-7 of 0x100 ignore programming.
// - 0x112/0x113 bits lock regions 1-16.
// - 0x214/0x215 bits lock regions 17-31.
// - Bit 7 of 0x215 ignores programming.
// - Programming a locked region is rejected.
// - Program outside valid range is ignored.
// - Out-of-range reads return indeterminate data.
// - Programming only clears bits, never sets.
`default_nettype none
package olm_pkg;
   localparam int unsigned ADDR_W = 10;
   localparam logic [9:0] OTP_BASE = 10'h100;
   localparam logic [9:0] OTP_LAST = 10'h2FF;
   localparam logic [9:0] SERIAL_LOCK_ADDR = 10'h100;
   localparam logic [9:0] LOWER_SERIAL_BASE = 10'h102;
   localparam logic [9:0] UPPER_SERIAL_BASE = 10'h10A;
   localparam logic [9:0] USER_LOCK_LOW_A = 10'h112;
   localparam logic [9:0] USER_LOCK_LOW_B = 10'h113;
   localparam logic [9:0] USER_LOW_BASE = 10'h114;
   localparam logic [9:0] USER_LOCK_HIGH_A = 10'h214;
   localparam logic [9:0] USER_LOCK_HIGH_B = 10'h215;
   localparam logic [9:0] USER_HIGH_BASE = 10'h216;
   localparam logic [9:0] USER_LAST_BASE = 10'h2F6;
   localparam logic [7:0] SERIAL_LOCK_MASK = 8'h03;
   localparam logic [7:0] HIGH_B_MASK = 8'h7F;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int unsigned MEM_DEPTH = 512;
   typedef struct packed {
      logic       prog;
      logic       rd;
      logic [9:0] addr;
      logic [7:0] data;
   } olm_req_s;
   typedef struct packed {
      logic       valid;
      logic       done;
      logic       rejected;
      logic [7:0] data;
   } olm_rsp_s;
endpackage
`default_nettype wire

// File: rtl/olm_otp_lock_map.sv
// One-time area decoder with lock enforcement and cell storage.
`default_nettype none
module olm_otp_lock_map (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clk_en,
   input  wire olm_pkg::olm_req_s req,
   output var  olm_pkg::olm_rsp_s rsp,
   output var  logic [31:0]      region_locked
);
   // Region index: 0 lower serial, 1 upper serial, 2..32 user 1..31.
   // Returns 6'h3F for lock bytes and reserved bytes, 6'h3E below the area.
   function automatic logic [5:0] region_of(input logic [9:0] a);
      logic [9:0] off;
      off = 10'h000;
      if (a < olm_pkg::OTP_BASE) begin
         region_of = 6'h3E;
      end else if (a < olm_pkg::LOWER_SERIAL_BASE) begin
         region_of = 6'h3F;
      end else if (a < olm_pkg::UPPER_SERIAL_BASE) begin
         region_of = 6'h00;
      end else if (a < olm_pkg::USER_LOCK_LOW_A) begin
         region_of = 6'h01;
      end else if (a < olm_pkg::USER_LOW_BASE) begin
         region_of = 6'h3F;
      end else if (a < olm_pkg::USER_LOCK_HIGH_A) begin
         off = a - olm_pkg::USER_LOW_BASE;
         region_of = 6'(off[9:4]) + 6'h02;
      end else if (a < olm_pkg::USER_HIGH_BASE) begin
         region_of = 6'h3F;
      end else begin
         off = a - olm_pkg::USER_HIGH_BASE;
         region_of = 6'(off[9:4]) + 6'h12;
      end
   endfunction

   // Cell index of a byte address; the area starts at the bottom of the
   // storage, so only the low nine address bits select a cell.
   function automatic logic [8:0] cell_of(input logic [9:0] a);
      cell_of = a[8:0] ^ olm_pkg::OTP_BASE[8:0];
   endfunction

   // Cells of the lock bytes, fixed by the address map.
   localparam logic [8:0] CELL_SER    = cell_of(olm_pkg::SERIAL_LOCK_ADDR);
   localparam logic [8:0] CELL_LOW_A  = cell_of(olm_pkg::USER_LOCK_LOW_A);
   localparam logic [8:0] CELL_LOW_B  = cell_of(olm_pkg::USER_LOCK_LOW_B);
   localparam logic [8:0] CELL_HIGH_A = cell_of(olm_pkg::USER_LOCK_HIGH_A);
   localparam logic [8:0] CELL_HIGH_B = cell_of(olm_pkg::USER_LOCK_HIGH_B);

   logic [7:0]  mem_q [olm_pkg::MEM_DEPTH];
   // Bit 32 holds user region 31; the status port shows bits 31:0 only.
   logic [32:0] lock_vec;
   logic [5:0]  reg_idx;
   logic        in_range;
   logic        is_locked;
   logic [7:0]  prog_mask;
   logic [8:0]  idx;

   assign idx = cell_of(req.addr);
   assign in_range = (req.addr >= olm_pkg::OTP_BASE) &&
                     (req.addr <= olm_pkg::OTP_LAST);
   assign reg_idx = region_of(req.addr);

   // Lock vector: lock bits are active low programmed cells (0 = locked).
   assign lock_vec[0] = ~mem_q[CELL_SER][0];
   assign lock_vec[1] = ~mem_q[CELL_SER][1];
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_lk
         assign lock_vec[2 + g]  = ~mem_q[CELL_LOW_A][g];
         assign lock_vec[10 + g] = ~mem_q[CELL_LOW_B][g];
         assign lock_vec[18 + g] = ~mem_q[CELL_HIGH_A][g];
         if (g < 7) begin : g_hb
            // The reserved top bit of this byte locks nothing.
            assign lock_vec[26 + g] = ~mem_q[CELL_HIGH_B][g];
         end
      end
   endgenerate

   // Lock and reserved bytes decode above 32 and are never locked, so
   // the lock bytes themselves stay programmable bit by bit.
   assign is_locked = (reg_idx <= 6'd32) && lock_vec[reg_idx];

   // Reserved lock bits never program, so writes to them are masked off.
   always_comb begin
      prog_mask = 8'hFF;
      if (req.addr == olm_pkg::SERIAL_LOCK_ADDR) begin
         prog_mask = olm_pkg::SERIAL_LOCK_MASK;
      end else if (req.addr == olm_pkg::USER_LOCK_HIGH_B) begin
         prog_mask = olm_pkg::HIGH_B_MASK;
      end else if (reg_idx == 6'h3F &&
                   req.addr != olm_pkg::USER_LOCK_LOW_A &&
                   req.addr != olm_pkg::USER_LOCK_LOW_B &&
                   req.addr != olm_pkg::USER_LOCK_HIGH_A) begin
         prog_mask = 8'h00;
      end
   end

   // The cells model erased storage; reset does not touch them, as a
   // true one-time array keeps its contents across resets.
   always_ff @(posedge clk) begin
      if (clk_en && req.prog && in_range && !is_locked) begin
         // Only ones may turn to zeros; a lock bit can never come back.
         mem_q[idx] <= mem_q[idx] & (req.data | ~prog_mask);
      end
   end

   initial begin
      for (int i = 0; i < olm_pkg::MEM_DEPTH; i++) begin
         mem_q[i] = olm_pkg::ERASED_BYTE;
      end
   end

   // Responses come one cycle after the request and hold while frozen.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsp <= '0;
      end else if (clk_en) begin
         rsp.valid <= req.rd;
         rsp.done <= req.prog;
         rsp.rejected <= req.prog && (!in_range || is_locked);
         // Out-of-range reads give erased data; callers must not trust it.
         rsp.data <= in_range ? mem_q[idx] : olm_pkg::ERASED_BYTE;
      end
   end

   // Lock status is registered so that the port comes from a flop; it
   // lags the cells by one enabled cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         region_locked <= 32'h0000_0000;
      end else if (clk_en) begin
         region_locked <= lock_vec[31:0];
      end
   end

   // Lock enforcement and the one-way nature of the cells.
   a_lock_blocks: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.prog && is_locked |=> rsp.rejected)
      else $error("Locked region program not rejected.");
   a_range_rej: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.prog && !in_range |=> rsp.done && rsp.rejected)
      else $error("Out of range program not rejected.");
   a_lock_sticky: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en |=> ((region_locked & ~lock_vec[31:0]) == 32'h0000_0000))
      else $error("A lock bit returned to unlocked.");
   a_serial_rsvd: assert property (
      @(posedge clk)
      mem_q[CELL_SER][7:2] == 6'h3F)
      else $error("Reserved serial lock bits changed.");
   a_highb_rsvd: assert property (
      @(posedge clk)
      mem_q[CELL_HIGH_B][7])
      else $error("Reserved high lock bit changed.");
   a_no_rise: assert property (
      @(posedge clk)
      clk_en && req.prog && in_range |=>
      ((mem_q[$past(idx)] & ~$past(mem_q[idx])) == 8'h00))
      else $error("A programmed bit returned to one.");
   a_user31_rej: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.prog && reg_idx == 6'd32 && lock_vec[32] |=> rsp.rejected)
      else $error("Last user region program not rejected.");
   a_lock_no_gate: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.prog && in_range && reg_idx == 6'h3F |=> !rsp.rejected)
      else $error("Lock byte program rejected.");

   // Address decode of the area.
   a_map_low: assert property (
      @(posedge clk) disable iff (sys_rst)
      req.addr == 10'h123 |-> reg_idx == 6'h02)
      else $error("Region one decode wrong.");
   a_map_high: assert property (
      @(posedge clk) disable iff (sys_rst)
      req.addr == 10'h2FF |-> reg_idx == 6'h20)
      else $error("Region thirty-one decode wrong.");
   a_map_serial: assert property (
      @(posedge clk) disable iff (sys_rst)
      req.addr == olm_pkg::UPPER_SERIAL_BASE |-> reg_idx == 6'h01)
      else $error("Upper serial decode wrong.");
   a_map_lock: assert property (
      @(posedge clk) disable iff (sys_rst)
      req.addr == olm_pkg::USER_LOCK_HIGH_B |-> reg_idx == 6'h3F)
      else $error("Lock byte decode wrong.");
   a_map_off: assert property (
      @(posedge clk) disable iff (sys_rst)
      req.addr < olm_pkg::OTP_BASE |-> reg_idx == 6'h3E)
      else $error("Below range decode wrong.");

   // Lock status port against the lock cells.
   a_lock_ser: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en |=> region_locked[1:0] == $past(~mem_q[CELL_SER][1:0]))
      else $error("Serial lock status wrong.");
   a_lock_map_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en |=> region_locked[9:2] == $past(~mem_q[CELL_LOW_A]))
      else $error("Low user lock status wrong.");
   a_lock_map_b: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en |=> region_locked[17:10] == $past(~mem_q[CELL_LOW_B]))
      else $error("Second user lock status wrong.");
   a_lock_map_c: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en |=> region_locked[25:18] == $past(~mem_q[CELL_HIGH_A]))
      else $error("Third user lock status wrong.");
   a_lock_map_d: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en |=> region_locked[31:26] == $past(~mem_q[CELL_HIGH_B][5:0]))
      else $error("Top user lock status wrong.");

   // Response framing: one answer per strobe, and nothing moves when frozen.
   a_read_pulse: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.rd |=> rsp.valid)
      else $error("Read gave no answer.");
   a_valid_only: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && !req.rd |=> !rsp.valid)
      else $error("Answer without a read.");
   a_prog_done: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.prog |=> rsp.done)
      else $error("Program gave no answer.");
   a_done_only: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && !req.prog |=> !rsp.done)
      else $error("Done without a program.");
   a_offrange_data: assert property (
      @(posedge clk) disable iff (sys_rst)
      clk_en && req.rd && !in_range |=> rsp.data == olm_pkg::ERASED_BYTE)
      else $error("Out of range read data wrong.");
   a_freeze_hold: assert property (
      @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(rsp) && $stable(region_locked))
      else $error("Outputs moved while frozen.");
   a_freeze_lock: assert property (
      @(posedge clk)
      !clk_en |=> $stable(lock_vec))
      else $error("Lock cells moved while frozen.");
endmodule
`default_nettype wire
